//--- include/dmaedr_pkg.sv
// Shared constants and carrier types for the DMA end and demand request block
package dmaedr_pkg;

  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned CMD_W = 32;
  localparam int unsigned CMD_FIFO_DEPTH = 16;
  localparam int unsigned PIN_SYNC_STAGES = 2;

  // Request queue depth per channel; channel 0 holds a single request
  localparam logic [2:0] QUEUE_MAX = 3'h4;
  localparam logic [2:0] QUEUE_MAX_CH0 = 3'h1;

  // Pointer step per transfer unit, in bytes
  localparam logic [ADDR_W-1:0] UNIT_BYTES = 32'h0000_0004;

  // Command word field codes
  localparam logic [2:0] SIZE_QUEUE_CLEAR = 3'h6;
  localparam logic [2:0] SIZE_TRANSFER_END = 3'h7;
  localparam logic [1:0] KIND_HANDSHAKE = 2'h0;
  localparam logic [1:0] KIND_QUEUE_CLEAR = 2'h2;
  localparam logic [1:0] CHAN_0 = 2'h0;
  localparam logic [1:0] CHAN_2 = 2'h2;

  // Timeout for the command word after the bus is offered
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CMD_WAIT_NS = 80;
  localparam int unsigned CMD_WAIT_CYC = CMD_WAIT_NS / CLK_PERIOD_NS;
  localparam int unsigned WAIT_W = 4;

  // Reset values
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

  // Request command word as it appears on the data bus
  typedef struct packed {
    logic [2:0] size_code_field;
    logic rsv_28;
    logic [1:0] channel_select;
    logic [1:0] request_kind_field;
    logic [23:0] rsv_low;
  } dmaedr_cmd_t;

  // Per channel working registers
  typedef struct packed {
    logic [ADDR_W-1:0] source_pointer;
    logic [ADDR_W-1:0] dest_pointer;
    logic [CNT_W-1:0] remaining_count;
  } dmaedr_chan_t;

  // CPU programming strobe for one channel
  typedef struct packed {
    logic we;
    logic [1:0] ch;
    dmaedr_chan_t val;
  } dmaedr_cfg_t;

endpackage

//--- hdl/dmaedr_fifo.sv
// Command word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dmaedr_fifo
  import dmaedr_pkg::*;
#(
  parameter int unsigned WIDTH = CMD_W,
  parameter int unsigned DEPTH = CMD_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // Pointer and fill count; full and empty come straight from the count
  always_comb
  begin
    o_in_ready = (cnt_q != (PW+1)'(DEPTH));
    o_out_valid = (cnt_q != '0);
    o_out_data = mem_q[rd_q];
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop)
    begin
      cnt_d = (PW+1)'(cnt_q + 1'b1);
    end
    else if (pop && !push)
    begin
      cnt_d = (PW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; the count guards every read
  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_in_data;
    end
  end

endmodule // dmaedr_fifo

//--- hdl/dmaedr_ctrl.sv
// Four channel DMA transfer end control and on-demand request front end
// How it works
// - A suspension lets the transfer unit in progress finish first.
// - A read cycle is always followed by its write cycle.
// - Count reaching zero stops the channel, sets end flag, raises irq if enabled.
// - Zero count stops at once, not by graceful suspension.
// - Clearing a channel enable suspends only it; end flag stays clear.
// - Address fault, nonmaskable stop or global disable stop all channels.
// - Address error sets fault flag, suspends all, keeps pointers and count.
// - Fault flag clears by writing zero only after reading it as one.
// - While fault flag set, all requests are ignored.
// - Nonmaskable interrupt sets stop flag, suspends all, keeps registers.
// - Stop flag clears by read one then write zero; requests ignored meanwhile.
// - Global disable suspends all, keeps registers; re-enable resumes.
// - Demand mode bit enables the on-demand request front end.
// - Bus claim gets bus free; command word with request pulse follows.
// - Channel select bits of a command pick the requested channel.
// - A request pulse alone repeats the last requested channel.
// - Claim and pulse together request channel 2 directly.
// - Command word carries size, channel select and kind fields.
// - Channel select outputs show the serviced channel in binary.
// - Queues hold up to four requests, channel 0 only one; extra requests are dropped.
`timescale 1ns/1ps
module dmaedr_ctrl
  import dmaedr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // CPU programming and control
  input wire dmaedr_cfg_t i_cfg,
  input wire logic [NUM_CH-1:0] i_channel_enable,
  input wire logic [NUM_CH-1:0] i_end_irq_enable,
  input wire logic [NUM_CH-1:0] i_end_flag_clr,
  input wire logic i_global_enable,
  input wire logic i_demand_mode_bit,
  input wire logic i_flag_rd,
  input wire logic i_fault_wr0,
  input wire logic i_nmi_wr0,
  // System events
  input wire logic i_addr_error,
  input wire logic i_nmi,
  // Status
  output logic [NUM_CH-1:0] o_end_flag,
  output logic [NUM_CH-1:0] o_completion_irq,
  output logic o_address_fault_flag,
  output logic o_nonmaskable_stop_flag,
  output dmaedr_chan_t [NUM_CH-1:0] o_chan_regs,
  output logic o_bus_owned,
  output logic o_read_cycle,
  // External device pins
  input wire logic i_bus_claim_request,
  input wire logic i_request_pulse,
  input wire logic [CMD_W-1:0] i_data,
  output logic o_bus_free_signal,
  output logic o_reply_strobe_n,
  output logic [1:0] o_channel_select
);

  typedef enum logic [1:0] {E_IDLE, E_READ, E_WRITE} dmaedr_eng_t;
  typedef enum logic [1:0] {H_IDLE, H_GRANT, H_WAIT} dmaedr_hs_t;

  function automatic logic [2:0] queue_limit(input logic [1:0] ch);
    queue_limit = (ch == CHAN_0) ? QUEUE_MAX_CH0 : QUEUE_MAX;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage 1 is read only by stage 2
  logic [CMD_W+1:0] pin_s1_q, pin_s2_q;
  logic claim_s, pulse_s, claim_prev_q;
  logic [CMD_W-1:0] data_s;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      claim_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= {i_bus_claim_request, i_request_pulse, i_data};
      pin_s2_q <= pin_s1_q;
      claim_prev_q <= claim_s;
    end
  end

  assign claim_s = pin_s2_q[CMD_W+1];
  assign pulse_s = pin_s2_q[CMD_W];
  assign data_s = pin_s2_q[CMD_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Declarations shared by the request and engine groups
  dmaedr_hs_t hs_q, hs_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic [1:0] last_q, last_d;
  logic have_last_q, have_last_d;
  dmaedr_eng_t eng_q, eng_d;
  logic [1:0] svc_q, svc_d;
  dmaedr_chan_t [NUM_CH-1:0] chan_q, chan_d;
  logic [NUM_CH-1:0][2:0] qcnt_q, qcnt_d;
  logic [NUM_CH-1:0] end_q, end_d;
  logic ae_q, ae_d, ae_seen_q, ae_seen_d;
  logic nmi_q, nmi_d, nmi_seen_q, nmi_seen_d;
  logic accept, run_ok, claim_rise;
  logic pin_req, push, in_ready, cmd_valid, cmd_take, cmd_fault;
  logic [1:0] pin_ch;
  logic [CMD_W-1:0] cmd_raw;
  dmaedr_cmd_t cmd;
  logic start, unit_done, last_unit;
  logic [1:0] pick;

  // Requests are only taken in demand mode and while no stop flag is set
  assign accept = i_demand_mode_bit && !ae_q && !nmi_q;
  assign run_ok = i_global_enable && !ae_q && !nmi_q;
  assign claim_rise = claim_s && !claim_prev_q;
  assign cmd = dmaedr_cmd_t'(cmd_raw);

  ////////////////////////////////////////////////////////////////////////
  // Command FIFO: bus is only offered while it has room, so a full FIFO
  // holds the external device off instead of losing a command word
  dmaedr_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(CMD_FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(push),
    .i_in_data(data_s),
    .o_in_ready(in_ready),
    .o_out_valid(cmd_valid),
    .o_out_data(cmd_raw),
    .i_out_ready(cmd_take)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin handshake: bus offer, command capture, repeat and direct requests
  always_comb
  begin
    hs_d = hs_q;
    wait_d = wait_q;
    last_d = last_q;
    have_last_d = have_last_q;
    pin_req = 1'b0;
    pin_ch = last_q;
    push = 1'b0;
    case (hs_q)
      H_IDLE:
      begin
        if (accept && claim_rise && pulse_s)
        begin
          pin_req = 1'b1;
          pin_ch = CHAN_2;
        end
        else if (accept && claim_rise && in_ready)
        begin
          hs_d = H_GRANT;
        end
        else if (accept && pulse_s && have_last_q)
        begin
          pin_req = 1'b1;
          pin_ch = last_q;
        end
      end
      H_GRANT:
      begin
        hs_d = H_WAIT;
        wait_d = '0;
      end
      H_WAIT:
      begin
        if (pulse_s)
        begin
          push = accept;
          hs_d = H_IDLE;
        end
        else if (wait_q == WAIT_W'(CMD_WAIT_CYC - 1))
        begin
          hs_d = H_IDLE;
        end
        else
        begin
          wait_d = WAIT_W'(wait_q + 1'b1);
        end
      end
      default:
      begin
        hs_d = H_IDLE;
      end
    endcase
    if (pin_req)
    begin
      last_d = pin_ch;
      have_last_d = 1'b1;
    end
    else if (cmd_take && !cmd_fault)
    begin
      last_d = cmd.channel_select;
      have_last_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      hs_q <= H_IDLE;
      wait_q <= '0;
      last_q <= CHAN_0;
      have_last_q <= 1'b0;
    end
    else
    begin
      hs_q <= hs_d;
      wait_q <= wait_d;
      last_q <= last_d;
      have_last_q <= have_last_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine, queues, end flags and stop flags
  always_comb
  begin
    eng_d = eng_q;
    svc_d = svc_q;
    chan_d = chan_q;
    qcnt_d = qcnt_q;
    end_d = end_q & ~i_end_flag_clr;
    start = 1'b0;
    pick = CHAN_0;
    // Commands drain only between units, at most one per idle engine cycle and none while a pin request is taken
    cmd_take = cmd_valid && (eng_q == E_IDLE) && !pin_req;
    cmd_fault = (cmd.channel_select == CHAN_0) && (cmd.request_kind_field != KIND_HANDSHAKE)
      && (cmd.request_kind_field != KIND_QUEUE_CLEAR);
    for (int c = NUM_CH - 1; c >= 0; c--)
    begin
      if (qcnt_q[c] != '0 && i_channel_enable[c] && chan_q[c].remaining_count != '0)
      begin
        pick = 2'(c);
        start = run_ok;
      end
    end
    unit_done = (eng_q == E_WRITE);
    last_unit = (chan_q[svc_q].remaining_count == CNT_W'(1));
    case (eng_q)
      E_IDLE:
      begin
        if (start)
        begin
          eng_d = E_READ;
          svc_d = pick;
          qcnt_d[pick] = 3'(qcnt_q[pick] - 1'b1);
        end
      end
      E_READ:
      begin
        eng_d = E_WRITE;
      end
      E_WRITE:
      begin
        eng_d = E_IDLE;
        chan_d[svc_q].source_pointer = chan_q[svc_q].source_pointer + UNIT_BYTES;
        chan_d[svc_q].dest_pointer = chan_q[svc_q].dest_pointer + UNIT_BYTES;
        chan_d[svc_q].remaining_count = CNT_W'(chan_q[svc_q].remaining_count - 1'b1);
        if (last_unit)
        begin
          end_d[svc_q] = 1'b1;
          qcnt_d[svc_q] = '0;
        end
      end
      default:
      begin
        eng_d = E_IDLE;
      end
    endcase
    // New requests; a full queue drops the extra one
    if (pin_req && qcnt_d[pin_ch] < queue_limit(pin_ch))
    begin
      qcnt_d[pin_ch] = 3'(qcnt_d[pin_ch] + 1'b1);
    end
    if (cmd_take && !cmd_fault)
    begin
      if (cmd.size_code_field == SIZE_QUEUE_CLEAR || cmd.size_code_field == SIZE_TRANSFER_END
        || cmd.request_kind_field == KIND_QUEUE_CLEAR)
      begin
        qcnt_d[cmd.channel_select] = '0;
      end
      else if (qcnt_d[cmd.channel_select] < queue_limit(cmd.channel_select))
      begin
        qcnt_d[cmd.channel_select] = 3'(qcnt_d[cmd.channel_select] + 1'b1);
        if (cmd.channel_select == CHAN_0 && cmd.rsv_low[CNT_W-1:0] != '0)
        begin
          chan_d[0].remaining_count = cmd.rsv_low[CNT_W-1:0];
        end
      end
    end
    // CPU programming overrides engine updates on the same channel
    if (i_cfg.we)
    begin
      chan_d[i_cfg.ch] = i_cfg.val;
    end
    // Flags: a new event wins over a clear in the same cycle
    ae_d = i_addr_error || (cmd_take && cmd_fault) || (ae_q && !(i_fault_wr0 && ae_seen_q));
    // A taken clear drops the read mark, so a fault arriving with it needs a fresh read
    ae_seen_d = ae_d && ((ae_seen_q && !i_fault_wr0) || (i_flag_rd && ae_q));
    nmi_d = i_nmi || (nmi_q && !(i_nmi_wr0 && nmi_seen_q));
    nmi_seen_d = nmi_d && ((nmi_seen_q && !i_nmi_wr0) || (i_flag_rd && nmi_q));
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      eng_q <= E_IDLE;
      svc_q <= CHAN_0;
      chan_q <= {NUM_CH{ADDR_RST, ADDR_RST, COUNT_RST}};
      qcnt_q <= '0;
      end_q <= '0;
      ae_q <= 1'b0;
      ae_seen_q <= 1'b0;
      nmi_q <= 1'b0;
      nmi_seen_q <= 1'b0;
    end
    else
    begin
      eng_q <= eng_d;
      svc_q <= svc_d;
      chan_q <= chan_d;
      qcnt_q <= qcnt_d;
      end_q <= end_d;
      ae_q <= ae_d;
      ae_seen_q <= ae_seen_d;
      nmi_q <= nmi_d;
      nmi_seen_q <= nmi_seen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_end_flag = end_q;
  assign o_completion_irq = end_q & i_end_irq_enable;
  assign o_address_fault_flag = ae_q;
  assign o_nonmaskable_stop_flag = nmi_q;
  assign o_chan_regs = chan_q;
  assign o_bus_owned = (eng_q != E_IDLE);
  assign o_read_cycle = (eng_q == E_READ);
  assign o_bus_free_signal = (hs_q == H_GRANT);
  assign o_reply_strobe_n = !unit_done;
  assign o_channel_select = svc_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_offer;
    hs_q == H_IDLE && accept && claim_rise && !pulse_s && in_ready;
  endsequence
  sequence s_unit;
    eng_q == E_READ ##1 eng_q == E_WRITE ##1 eng_q == E_IDLE;
  endsequence

  a_read_then_write: assert property (eng_q == E_READ |-> ##1 eng_q == E_WRITE)
    else $error("read cycle not followed by write cycle");
  a_unit_whole: assert property (eng_q == E_IDLE && start |=> s_unit)
    else $error("transfer unit cut short");
  a_stop_holds: assert property ((ae_q || nmi_q || !i_global_enable) && eng_q == E_IDLE
    |=> eng_q == E_IDLE)
    else $error("transfer started while stopped");
  a_end_on_zero: assert property (eng_q == E_WRITE && last_unit && !i_cfg.we
    |=> o_end_flag[$past(svc_q)] && o_completion_irq[$past(svc_q)] == i_end_irq_enable[$past(svc_q)])
    else $error("end flag or irq missing at zero count");
  a_no_flag_early: assert property (eng_q == E_WRITE && !last_unit && !end_q[svc_q]
    && !i_end_flag_clr[svc_q] |=> !o_end_flag[$past(svc_q)])
    else $error("end flag set without zero count");
  a_fault_clear: assert property ($fell(ae_q) |-> $past(ae_seen_q) && $past(i_fault_wr0))
    else $error("fault flag cleared without read of one");
  a_nmi_sets: assert property (i_nmi |=> nmi_q ##1 nmi_q)
    else $error("nonmaskable stop flag not held");
  a_offer_seq: assert property (s_offer |=> o_bus_free_signal ##1 hs_q == H_WAIT)
    else $error("bus free not offered after claim");
  a_queue_full: assert property (qcnt_q[1] <= QUEUE_MAX && qcnt_q[2] <= QUEUE_MAX
    && qcnt_q[3] <= QUEUE_MAX && qcnt_q[0] <= QUEUE_MAX_CH0)
    else $error("request queue over its depth");
  a_fault_no_take: assert property (ae_q || nmi_q |-> !push && !pin_req)
    else $error("request taken while stop flag set");
  a_select_held: assert property (eng_q == E_WRITE |-> $stable(o_channel_select))
    else $error("channel select moved during a unit");

endmodule // dmaedr_ctrl

//--- test/dmaedr_ext_dev.sv
// External requesting device model for the demand request pins
`timescale 1ns/1ps
module dmaedr_ext_dev
  import dmaedr_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Grant from the controller
  input wire logic i_bus_free_signal,
  // Request pins toward the controller
  output logic o_bus_claim_request,
  output logic o_request_pulse,
  output logic [CMD_W-1:0] o_data
);
  int wait_n;

  //////////////////////////////////////////////////////////////////////////////
  // Claim and pulse idle low, data starts all ones; a released data bus shows the inverse of the last word
  initial
  begin
    o_bus_claim_request = 1'b0;
    o_request_pulse = 1'b0;
    o_data = 32'hffff_ffff;
  end

  // Claim, wait for the grant, drive the word with the pulse one cycle on
  // An extra gap models a slow device; the controller waits eight cycles
  task automatic send_cmd(input logic [CMD_W-1:0] word, input int gap, output bit granted);
    granted = 1'b0;
    o_bus_claim_request <= 1'b1;
    for (wait_n = 0; wait_n < 16 && !granted; wait_n++)
    begin
      @(posedge i_ref_clk);
      granted = (i_bus_free_signal === 1'b1);
    end
    if (granted)
    begin
      repeat (gap + 1) @(posedge i_ref_clk);
      o_data <= word;
      o_request_pulse <= 1'b1;
      @(posedge i_ref_clk);
      o_request_pulse <= 1'b0;
      o_data <= ~word;
    end
    o_bus_claim_request <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
  endtask

  // Pulse alone, never right after a grant, repeats the last channel
  task automatic pulse_only();
    o_request_pulse <= 1'b1;
    @(posedge i_ref_clk);
    o_request_pulse <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
  endtask

  // Claim and pulse together ask channel 2 directly
  task automatic direct_req();
    o_bus_claim_request <= 1'b1;
    o_request_pulse <= 1'b1;
    @(posedge i_ref_clk);
    o_bus_claim_request <= 1'b0;
    o_request_pulse <= 1'b0;
    repeat (14) @(posedge i_ref_clk);
  endtask
endmodule // dmaedr_ext_dev

//--- test/dmaedr_tb_top.sv
// Self-checking bench for the DMA end control and demand request block
`timescale 1ns/1ps
module dmaedr_tb_top
  import dmaedr_pkg::*;
;
  logic clk, rst, gen, demand_mode_bit, frd, fwr0, nwr0, aerr, nmi, claim, pulse, bfree, strb_n, rdc, own;
  logic aflag, nflag;
  bit g0;
  logic [3:0] ch_en, irq_en, efc, o_end, o_irq;
  logic [1:0] o_sel, exp_ch;
  logic [CMD_W-1:0] dbus;
  dmaedr_cfg_t cfg;
  dmaedr_chan_t [NUM_CH-1:0] regs;
  logic [31:0] m_src [4];
  logic [31:0] m_dst [4];
  logic [15:0] m_cnt [4];
  logic [3:0] m_end;
  logic [15:0] lf = 16'h4272;
  int bad_count, checked, units, cyc, n, u0;

  //////////////////////////////////////////////////////////////////////////////
  // Devices under test and the requesting device
  dmaedr_ctrl dmaedr_ctrl_inst (.i_ref_clk(clk), .i_rst(rst), .i_cfg(cfg),
    .i_channel_enable(ch_en), .i_end_irq_enable(irq_en), .i_end_flag_clr(efc),
    .i_global_enable(gen), .i_demand_mode_bit(demand_mode_bit), .i_flag_rd(frd), .i_fault_wr0(fwr0),
    .i_nmi_wr0(nwr0), .i_addr_error(aerr), .i_nmi(nmi), .o_end_flag(o_end),
    .o_completion_irq(o_irq), .o_address_fault_flag(aflag), .o_nonmaskable_stop_flag(nflag),
    .o_chan_regs(regs), .o_bus_owned(own), .o_read_cycle(rdc), .i_bus_claim_request(claim),
    .i_request_pulse(pulse), .i_data(dbus), .o_bus_free_signal(bfree),
    .o_reply_strobe_n(strb_n), .o_channel_select(o_sel));
  dmaedr_ext_dev dmaedr_ext_dev_inst (.i_ref_clk(clk), .i_bus_free_signal(bfree),
    .o_bus_claim_request(claim), .o_request_pulse(pulse), .o_data(dbus));

  // Clock, and a cycle ceiling so a hang still ends in the report
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (e !== g)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Each write strobe is one finished unit; the model steps that channel
  always @(posedge clk)
  begin
    if (!rst && strb_n === 1'b0)
    begin
      units++;
      chk("channel_select", exp_ch, o_sel);
      m_src[exp_ch] += 32'h4;
      m_dst[exp_ch] += 32'h4;
      m_cnt[exp_ch] -= 16'h1;
      if (m_cnt[exp_ch] == 16'h0)
        m_end[exp_ch] = 1'b1;
    end
  end

  // Programming also clears a stale end flag of that channel
  task automatic prog(input logic [1:0] c, input logic [15:0] cnt);
    lf = lfsr(lf);
    m_src[c] = {lf, 16'h0100};
    m_dst[c] = {16'h2000, lf[13:0], 2'h0};
    m_cnt[c] = cnt;
    m_end[c] = 1'b0;
    cfg <= '{we: 1'b1, ch: c, val: '{m_src[c], m_dst[c], cnt}};
    efc <= 4'h1 << c;
    @(posedge clk);
    cfg.we <= 1'b0;
    efc <= 4'h0;
    @(posedge clk);
  endtask

  task automatic cmp_regs();
    for (int c = 0; c < 4; c++)
    begin
      chk("source_pointer", m_src[c], regs[c].source_pointer);
      chk("dest_pointer", m_dst[c], regs[c].dest_pointer);
      chk("remaining_count", m_cnt[c], regs[c].remaining_count);
    end
    chk("end_flag", m_end, o_end);
    chk("completion_irq", m_end & irq_en, o_irq);
  endtask

  // Request by command word with a random extra delay at the device
  task automatic req(input logic [1:0] c, input logic [1:0] kind, input bit exp_g);
    bit g;
    lf = lfsr(lf);
    dmaedr_ext_dev_inst.send_cmd({3'h0, 1'b0, c, kind, 24'h000000}, lf[1:0], g);
    chk("bus_free_grant", exp_g, g);
  endtask

  task automatic wait_units(input int cnt);
    for (int t = 0; t < 300 && units < cnt; t++)
      @(posedge clk);
    // One more edge so the registers of the last unit have landed
    @(posedge clk);
    chk("units", cnt, units);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst, gen, demand_mode_bit, frd, fwr0, nwr0, aerr, nmi} = 8'h80;
    {ch_en, irq_en, efc, exp_ch} = 14'h0;
    cfg = '0;
    m_end = 4'h0;
    for (int c = 0; c < 4; c++)
      {m_src[c], m_dst[c], m_cnt[c]} = 80'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_regs();
    chk("idle_pins", 3'h2, {bfree, strb_n, own});
    {gen, demand_mode_bit, ch_en, irq_en} <= 10'h3f2;
    // Two requests use up a count of two; end flag and interrupt follow
    prog(2'h1, 16'h2);
    exp_ch <= 2'h1;
    req(2'h1, 2'h0, 1'b1);
    req(2'h1, 2'h0, 1'b1);
    wait_units(2);
    cmp_regs();
    // Queue of four fills while disabled; the fifth is dropped
    prog(2'h3, 16'h6);
    exp_ch <= 2'h3;
    gen <= 1'b0;
    for (n = 0; n < 5; n++)
      req(2'h3, 2'h0, 1'b1);
    gen <= 1'b1;
    wait_units(6);
    repeat (40) @(posedge clk);
    chk("units", 6, units);
    dmaedr_ext_dev_inst.pulse_only();
    wait_units(7);
    // Direct channel 2, then a disabled channel keeps its request pending
    prog(2'h2, 16'h3);
    exp_ch <= 2'h2;
    dmaedr_ext_dev_inst.direct_req();
    wait_units(8);
    ch_en[2] <= 1'b0;
    dmaedr_ext_dev_inst.direct_req();
    repeat (30) @(posedge clk);
    chk("units", 8, units);
    cmp_regs();
    ch_en[2] <= 1'b1;
    wait_units(9);
    // Global disable during a unit: it finishes, the next one waits
    prog(2'h1, 16'h3);
    exp_ch <= 2'h1;
    gen <= 1'b0;
    req(2'h1, 2'h0, 1'b1);
    req(2'h1, 2'h0, 1'b1);
    gen <= 1'b1;
    for (n = 0; n < 100 && rdc !== 1'b1; n++)
      @(posedge clk);
    gen <= 1'b0;
    wait_units(10);
    repeat (30) @(posedge clk);
    chk("units", 10, units);
    gen <= 1'b1;
    wait_units(11);
    // Fault and nonmaskable stop: refuse requests, clear only after a read
    for (n = 0; n < 2; n++)
    begin
      aerr <= (n == 0);
      nmi <= (n == 1);
      @(posedge clk);
      {aerr, nmi} <= 2'h0;
      repeat (2) @(posedge clk);
      chk("stop_flags", (n == 0) ? 2'h2 : 2'h1, {aflag, nflag});
      u0 = units;
      req(2'h1, 2'h0, 1'b0);
      chk("units", u0, units);
      fwr0 <= (n == 0);
      nwr0 <= (n == 1);
      @(posedge clk);
      {fwr0, nwr0} <= 2'h0;
      repeat (2) @(posedge clk);
      chk("stop_flags", (n == 0) ? 2'h2 : 2'h1, {aflag, nflag});
      frd <= 1'b1;
      @(posedge clk);
      frd <= 1'b0;
      fwr0 <= (n == 0);
      nwr0 <= (n == 1);
      @(posedge clk);
      {fwr0, nwr0} <= 2'h0;
      repeat (2) @(posedge clk);
      chk("stop_flags", 2'h0, {aflag, nflag});
      cmp_regs();
    end
    // A channel 0 command of a forbidden kind halts with an address fault
    req(2'h0, 2'h1, 1'b1);
    repeat (4) @(posedge clk);
    chk("address_fault_flag", 1'b1, aflag);
    // Reprogram the faulting channel before the read and the clear
    prog(2'h0, 16'h1);
    frd <= 1'b1;
    @(posedge clk);
    frd <= 1'b0;
    fwr0 <= 1'b1;
    @(posedge clk);
    fwr0 <= 1'b0;
    exp_ch <= 2'h0;
    req(2'h0, 2'h0, 1'b1);
    wait_units(12);
    cmp_regs();
    demand_mode_bit <= 1'b0;
    req(2'h1, 2'h0, 1'b0);
    // Queue clear by size code drops pending work; then a channel 0 word loads its count
    demand_mode_bit <= 1'b1;
    gen <= 1'b0;
    req(2'h1, 2'h0, 1'b1);
    req(2'h1, 2'h0, 1'b1);
    dmaedr_ext_dev_inst.send_cmd({SIZE_QUEUE_CLEAR, 1'b0, 2'h1, 2'h0, 24'h000000}, 0, g0);
    chk("bus_free_grant", 1'b1, g0);
    gen <= 1'b1;
    repeat (30) @(posedge clk);
    chk("units", 12, units);
    cmp_regs();
    m_cnt[0] = 16'h2;
    dmaedr_ext_dev_inst.send_cmd({3'h0, 1'b0, 2'h0, 2'h0, 24'h000002}, 0, g0);
    chk("bus_free_grant", 1'b1, g0);
    wait_units(13);
    cmp_regs();
    summarize();
  end
endmodule // dmaedr_tb_top
